// >>> common/bsrm_pkg.sv
// ********************************************************
// burner status register map constants
// ********************************************************
package bsrm_pkg;

  // register offsets (input and holding views share them)
  localparam logic [15:0] OFF_RUN_VALVE = 16'h0000;
  localparam logic [15:0] OFF_INPUT_FLAGS = 16'h0001;
  localparam logic [15:0] OFF_LIMIT_TEMP = 16'h0002;
  localparam logic [15:0] OFF_PROCESS_TEMP = 16'h0003;
  localparam logic [15:0] OFF_AUX_TEMP = 16'h0004;
  localparam logic [15:0] OFF_FLAME_QUALITY = 16'h0005;
  localparam logic [15:0] OFF_LAST = 16'h0005;

  // read function codes
  localparam logic [7:0] FN_READ_HOLDING = 8'h03;
  localparam logic [7:0] FN_READ_INPUT = 8'h04;

  // field positions
  localparam int RUN_BIT_LSB = 0;
  localparam int RUN_BIT_WIDTH = 4;
  localparam int IN_BIT_LSB = 0;
  localparam int IN_BIT_WIDTH = 8;
  localparam int FLAG_BIT_LSB = 8;
  localparam int FLAG_BIT_WIDTH = 6;

  // temperature span in whole degrees celsius
  localparam logic signed [15:0] TEMP_MIN_C = -16'sd50;
  localparam logic signed [15:0] TEMP_MAX_C = 16'sd1350;
  localparam logic [15:0] QUALITY_MAX = 16'h0064;

  // values after reset
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_COUNT = 16'h0000;

  // reader states
  typedef enum logic [1:0] {
    BSRM_IDLE = 2'b00,
    BSRM_HIGH = 2'b01,
    BSRM_LOW = 2'b11
  } bsrm_state_t;

endpackage : bsrm_pkg

// >>> design/bsrm_reader.sv
`timescale 1ns/10ps
module bsrm_reader (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // live status from the burner controller (same clock)
  input wire logic run_i,
  input wire logic [2:0] valve_i,
  input wire logic [7:0] input_state_i,
  input wire logic [5:0] alarm_flag_i,
  input wire logic signed [15:0] limit_temp_c_i,
  input wire logic signed [15:0] process_temp_c_i,
  input wire logic signed [15:0] aux_temp_c_i,
  input wire logic [7:0] flame_quality_i,
  // read request from the protocol engine
  input wire logic req_valid_i,
  input wire logic [7:0] req_function_i,
  input wire logic [15:0] req_offset_i,
  input wire logic [15:0] req_count_i,
  output logic req_ready_o,
  output logic req_error_o,
  // response byte stream
  output logic byte_valid_o,
  output logic [7:0] byte_o,
  output logic byte_last_o,
  input wire logic byte_ready_i
);

  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    // which byte of the current register is on the stream
    bsrm_pkg::bsrm_state_t st;
    // register being sent and registers still to send, this one included
    logic [15:0] offset;
    logic [15:0] remain;
    // snapshot of that register, so both bytes come from one instant
    logic [15:0] word;
    // byte offered on the stream with its qualifiers
    logic [7:0] out_byte;
    logic out_valid;
    logic out_last;
    // one-cycle refusal pulse
    logic err;
  } bsrm_regs_t;

  bsrm_regs_t r;
  bsrm_regs_t next_r;

  // ********************************************************
  // register images
  // ********************************************************
  // run and valve word: run in bit 0, three valve states above it, the rest zero
  function automatic logic [15:0] bsrm_run_word(input logic run, input logic [2:0] valve);
    logic [15:0] w;
    w = bsrm_pkg::RESET_WORD;
    w[bsrm_pkg::RUN_BIT_LSB +: bsrm_pkg::RUN_BIT_WIDTH] = {valve, run};
    return w;
  endfunction : bsrm_run_word

  // live input and alarm word: input states in the low byte, alarms from bit 8, top bits zero
  function automatic logic [15:0] bsrm_flag_word(input logic [7:0] live_state, input logic [5:0] live_flag);
    logic [15:0] w;
    w = bsrm_pkg::RESET_WORD;
    w[bsrm_pkg::IN_BIT_LSB +: bsrm_pkg::IN_BIT_WIDTH] = live_state;
    w[bsrm_pkg::FLAG_BIT_LSB +: bsrm_pkg::FLAG_BIT_WIDTH] = live_flag;
    return w;
  endfunction : bsrm_flag_word

  // pick one register image by offset from the live inputs; unmapped offsets read zero
  function automatic logic [15:0] bsrm_word(input logic [15:0] off);
    logic [15:0] w;
    w = bsrm_pkg::RESET_WORD;
    case (off)
      // run and valve states
      bsrm_pkg::OFF_RUN_VALVE: w = bsrm_run_word(run_i, valve_i);
      // live inputs and non-latched alarms
      bsrm_pkg::OFF_INPUT_FLAGS: w = bsrm_flag_word(input_state_i, alarm_flag_i);
      // thermocouples pass through as signed whole celsius, never converted to the display unit
      bsrm_pkg::OFF_LIMIT_TEMP: w = limit_temp_c_i;
      bsrm_pkg::OFF_PROCESS_TEMP: w = process_temp_c_i;
      bsrm_pkg::OFF_AUX_TEMP: w = aux_temp_c_i;
      // flame quality percentage in the low byte
      bsrm_pkg::OFF_FLAME_QUALITY: w = {8'h00, flame_quality_i};
      default: w = bsrm_pkg::RESET_WORD;
    endcase
    return w;
  endfunction : bsrm_word

  // the most significant byte leads, so it is the byte loaded with each new word
  function automatic logic [7:0] bsrm_msb(input logic [15:0] word);
    return word[15:8];
  endfunction : bsrm_msb

  // the least significant byte follows directly after it
  function automatic logic [7:0] bsrm_lsb(input logic [15:0] word);
    return word[7:0];
  endfunction : bsrm_lsb

  // ********************************************************
  // request legality
  // ********************************************************
  // only the two register-read functions are served, both from the one map
  logic fn_ok;
  // a read must ask for at least one register
  logic count_ok;
  // the last register asked for must lie inside the map
  logic span_ok;
  logic range_ok;
  // one bit wider than an offset so that a wrap past the top is still caught
  logic [16:0] end_off;
  assign fn_ok = (req_function_i == bsrm_pkg::FN_READ_INPUT) ||
                 (req_function_i == bsrm_pkg::FN_READ_HOLDING);
  assign count_ok = (req_count_i != bsrm_pkg::RESET_COUNT);
  assign end_off = {1'b0, req_offset_i} + {1'b0, req_count_i};
  assign span_ok = (end_off <= ({1'b0, bsrm_pkg::OFF_LAST} + 17'h0_0001));
  assign range_ok = count_ok && span_ok;

  // ********************************************************
  // word snapshots
  // ********************************************************
  // image of the requested start register, loaded when a read is accepted
  logic [15:0] first_word;
  // offset and image of the register after the one on the stream
  logic [15:0] step_off;
  logic [15:0] step_word;
  assign step_off = r.offset + 16'h0001;

  // handshake outputs
  // a new read is taken only while idle
  assign req_ready_o = (r.st == bsrm_pkg::BSRM_IDLE);
  // refusal pulse and byte stream come straight from flops
  assign req_error_o = r.err;
  assign byte_valid_o = r.out_valid;
  assign byte_o = r.out_byte;
  assign byte_last_o = r.out_last;

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    // images of the start register and of the next register, read live
    first_word = bsrm_word(req_offset_i);
    step_word = bsrm_word(step_off);
    next_r = r;
    next_r.err = 1'b0;
    unique case (r.st)
      // idle: take a request or refuse it
      bsrm_pkg::BSRM_IDLE: begin
        if (req_valid_i) begin
          if (fn_ok && range_ok) begin
            next_r.word = first_word;
            next_r.offset = req_offset_i;
            next_r.remain = req_count_i;
            next_r.out_byte = bsrm_msb(first_word);
            next_r.out_valid = 1'b1;
            next_r.out_last = 1'b0;
            next_r.st = bsrm_pkg::BSRM_HIGH;
          end else begin
            // refused: pulse the error and stay idle, nothing goes on the stream
            next_r.err = 1'b1;
          end
        end
      end
      // high byte on the stream: once taken, offer the low byte of the same snapshot
      bsrm_pkg::BSRM_HIGH: begin
        if (byte_ready_i) begin
          next_r.out_byte = bsrm_lsb(r.word);
          next_r.out_last = (r.remain == 16'h0001);
          next_r.st = bsrm_pkg::BSRM_LOW;
        end
      end
      // low byte on the stream: once taken, finish or move to the next register
      bsrm_pkg::BSRM_LOW: begin
        if (byte_ready_i) begin
          if (r.remain == 16'h0001) begin
            // last register done: drop the stream and go idle
            next_r.out_valid = 1'b0;
            next_r.out_last = 1'b0;
            next_r.st = bsrm_pkg::BSRM_IDLE;
          end else begin
            // more to send: next offset with a fresh snapshot
            next_r.offset = step_off;
            next_r.remain = r.remain - 16'h0001;
            next_r.word = step_word;
            next_r.out_byte = bsrm_msb(step_word);
            next_r.out_last = 1'b0;
            next_r.st = bsrm_pkg::BSRM_HIGH;
          end
        end
      end
      default: next_r.st = bsrm_pkg::BSRM_IDLE;
    endcase
  end

  // ********************************************************
  // registers
  // ********************************************************
  always_ff @(posedge clk_i) begin
    // reset: idle, nothing offered, no error
    if (sys_rst_i) begin
      r.st <= bsrm_pkg::BSRM_IDLE;
      r.offset <= bsrm_pkg::RESET_WORD;
      r.remain <= bsrm_pkg::RESET_COUNT;
      r.word <= bsrm_pkg::RESET_WORD;
      r.out_byte <= bsrm_pkg::RESET_BYTE;
      r.out_valid <= 1'b0;
      r.out_last <= 1'b0;
      r.err <= 1'b0;
    end else begin
      // otherwise take the copy filled by the next-state logic
      r <= next_r;
    end
  end

endmodule : bsrm_reader

// >>> dv/bsrm_master.sv
`timescale 1ns/10ps
// ****
// response consumer with random stalls
// ****
module bsrm_master (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // byte acceptance
  output logic byte_ready_o = 1'b0
);
  int seed = 32'h0ce0;
  // takes bytes in arrival order, stalling about one cycle in four
  always @(posedge clk_i) byte_ready_o <= !sys_rst_i && ($random(seed) % 4 != 0);
endmodule : bsrm_master

// >>> dv/bsrm_props.sv
`timescale 1ns/10ps
// ****
// reader port checks
// ****
module bsrm_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // watched ports
  input wire logic run_i,
  input wire logic [2:0] valve_i,
  input wire logic req_valid_i,
  input wire logic [7:0] req_function_i,
  input wire logic [15:0] req_offset_i,
  input wire logic [15:0] req_count_i,
  input wire logic req_ready_o,
  input wire logic req_error_o,
  input wire logic byte_valid_o,
  input wire logic [7:0] byte_o,
  input wire logic byte_last_o,
  input wire logic byte_ready_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // accepted request and its legality
  wire tk = req_valid_i && req_ready_o;
  wire ok = req_function_i inside {8'h03, 8'h04} && req_count_i != 16'h0000 && {1'b0, req_offset_i} + req_count_i <= 17'h0_0006;
  sequence s_go; tk && ok; endsequence
  sequence s_w0; tk && ok && req_offset_i == 16'h0000 ##1 byte_ready_i; endsequence
  sequence s_one; tk && ok && req_count_i == 16'h0001 ##1 byte_ready_i; endsequence
  property p_ref; tk && !ok |=> (req_error_o && !byte_valid_o) ##1 !req_error_o; endproperty
  a_ref: assert property (p_ref) else $error("refusal wrong");
  property p_go; s_go |=> byte_valid_o && !req_ready_o && !req_error_o; endproperty
  a_go: assert property (p_go) else $error("no answer");
  property p_hold; byte_valid_o && !byte_ready_i |=> byte_valid_o && $stable(byte_o) && $stable(byte_last_o); endproperty
  a_hold: assert property (p_hold) else $error("byte not held");
  property p_busy; byte_valid_o |-> !req_ready_o; endproperty
  a_busy: assert property (p_busy) else $error("ready while busy");
  property p_end; byte_valid_o && byte_ready_i && byte_last_o |=> !byte_valid_o && req_ready_o; endproperty
  a_end: assert property (p_end) else $error("no end");
  property p_w0; s_w0 |=> byte_o == {4'h0, $past(valve_i, 2), $past(run_i, 2)}; endproperty
  a_w0: assert property (p_w0) else $error("run byte wrong");
  property p_msb0; tk && ok && (req_offset_i == 16'h0000 || req_offset_i == 16'h0005) |=> byte_o == 8'h00; endproperty
  a_msb0: assert property (p_msb0) else $error("high byte set");
  property p_one; s_one |=> byte_last_o; endproperty
  a_one: assert property (p_one) else $error("last missing");
endmodule : bsrm_props
bind bsrm_reader bsrm_props props_u (
  .clk_i(clk_i),
  .sys_rst_i(sys_rst_i),
  .run_i(run_i),
  .valve_i(valve_i),
  .req_valid_i(req_valid_i),
  .req_function_i(req_function_i),
  .req_offset_i(req_offset_i),
  .req_count_i(req_count_i),
  .req_ready_o(req_ready_o),
  .req_error_o(req_error_o),
  .byte_valid_o(byte_valid_o),
  .byte_o(byte_o),
  .byte_last_o(byte_last_o),
  .byte_ready_i(byte_ready_i)
);

// >>> dv/bsrm_reader_tb.sv
`timescale 1ns/10ps
module bsrm_reader_tb;
  // ****
  // stimulus and checks
  // ****
  logic clk_i = 0, sys_rst_i = 1, run_i = 0, req_valid_i = 0, byte_ready_i, req_ready_o, req_error_o;
  logic byte_valid_o, byte_last_o;
  logic [2:0] valve_i = 0;
  logic [5:0] alarm_flag_i = 0;
  logic [7:0] input_state_i = 0, flame_quality_i = 0, req_function_i = 0, byte_o;
  logic signed [15:0] limit_temp_c_i = 0, process_temp_c_i = 0, aux_temp_c_i = 0;
  logic [15:0] req_offset_i = 0, req_count_i = 0, off;
  logic [15:0] w[6];
  logic [8:0] exp_q[$];
  int seed = 32'h0ce0, err_total = 0, num_checks = 0, i;
  initial forever #50 clk_i = ~clk_i;
  bsrm_reader dut_u (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .run_i(run_i),
    .valve_i(valve_i),
    .input_state_i(input_state_i),
    .alarm_flag_i(alarm_flag_i),
    .limit_temp_c_i(limit_temp_c_i),
    .process_temp_c_i(process_temp_c_i),
    .aux_temp_c_i(aux_temp_c_i),
    .flame_quality_i(flame_quality_i),
    .req_valid_i(req_valid_i),
    .req_function_i(req_function_i),
    .req_offset_i(req_offset_i),
    .req_count_i(req_count_i),
    .req_ready_o(req_ready_o),
    .req_error_o(req_error_o),
    .byte_valid_o(byte_valid_o),
    .byte_o(byte_o),
    .byte_last_o(byte_last_o),
    .byte_ready_i(byte_ready_i)
  );
  bsrm_master part_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .byte_ready_o(byte_ready_i));
  task automatic chk(string n, logic [8:0] e, logic [8:0] s);
    num_checks++;
    if (s !== e) begin
      $display("mismatch %s exp %h got %h", n, e, s);
      err_total++;
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // one read: random live status, request, expected bytes queued
  task automatic rd(logic [7:0] fn, logic [15:0] of, logic [15:0] cnt, logic bad);
    int k;
    for (k = 0; k < 5; k++) w[k] = 16'($random(seed));
    w[0] = w[0] & 16'h000f;
    w[1] = w[1] & 16'h3fff;
    for (k = 2; k < 5; k++) w[k] = 16'($unsigned(w[k]) % 1401 - 50);
    w[5] = 16'($unsigned($random(seed)) % 101);
    @(posedge clk_i);
    {valve_i, run_i} <= w[0][3:0];
    {alarm_flag_i, input_state_i} <= w[1][13:0];
    limit_temp_c_i <= w[2];
    process_temp_c_i <= w[3];
    aux_temp_c_i <= w[4];
    flame_quality_i <= w[5][7:0];
    req_valid_i <= 1;
    req_function_i <= fn;
    req_offset_i <= of;
    req_count_i <= cnt;
    if (!bad) begin
      for (k = 0; k < 2 * cnt; k++) begin
        exp_q.push_back({k == 2 * cnt - 1, 8'(w[of + k / 2] >> (k[0] ? 0 : 8))});
      end
    end
    @(posedge clk_i);
    req_valid_i <= 0;
    #1 chk("req_error_o", {8'h00, bad}, {8'h00, req_error_o});
    for (k = 0; k < 200 && !req_ready_o; k++) begin
      @(posedge clk_i);
      #1;
    end
    if (k == 200) begin
      err_total++;
      tally_and_finish();
    end
  endtask : rd
  // mid-cycle, take each byte that the coming edge accepts against the oldest note
  always @(negedge clk_i) begin
    if (!sys_rst_i && byte_valid_o && byte_ready_i) chk("byte", exp_q.size() ? exp_q.pop_front() : 9'h1ff, {byte_last_o, byte_o});
  end
  initial begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 0;
    for (i = 3; i < 5; i++) rd(8'(i), 16'h0000, 16'h0006, 0);
    for (i = 0; i < 30; i++) begin
      off = 16'($unsigned($random(seed)) % 6);
      rd(8'(3 + i % 2), off, 16'(1 + $unsigned($random(seed)) % (6 - off)), 0);
    end
    rd(8'h06, 16'h0000, 16'h0001, 1);
    rd(8'h04, 16'h0000, 16'h0000, 1);
    rd(8'h03, 16'h0005, 16'h0002, 1);
    rd(8'h04, 16'hffff, 16'h0002, 1);
    repeat (3) @(posedge clk_i);
    chk("queue", 9'h000, 9'(exp_q.size()));
    tally_and_finish();
  end
endmodule : bsrm_reader_tb
